// *** design/opc_pkg.sv ***
// Constants for the output and power control byte of the clock generator.
package opc_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_ADDR_OUTPUT_AND_POWER_CONTROL = 8'h24;
  localparam logic [7:0] OPC_RESET_VALUE = 8'h8c; // Bits 7, 3 and 2 set.
  localparam logic [7:0] OPC_WRITE_MASK = 8'hdf; // Bit 5 is reserved.
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int OPC_BIT_CHIP_SLEEP_CONTROL = 7;
  localparam int OPC_BIT_REF_FREE_RUN = 6;
  localparam int OPC_BIT_RESERVED = 5;
  localparam int OPC_BIT_SINGLE_OUT_ONE_DEFAULT = 4;
  localparam int OPC_BIT_SINGLE_OUT_ONE_SOURCE_SELECT = 3;
  localparam int OPC_BIT_REF_OUT_GATE = 2;
  localparam int OPC_BIT_CHANNEL_THREE_GATE = 1;
  localparam int OPC_BIT_CHANNEL_TWO_GATE = 0;
  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  localparam int OPC_SYNC_INPUTS = 3; // 32k, fourth and fifth divider.
  localparam int OPC_SRC_32K = 0;
  localparam int OPC_SRC_FOURTH_DIVIDER = 1;
  localparam int OPC_SRC_FIFTH_DIVIDER = 2;
endpackage

// *** design/opc_level_sync.sv ***
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module opc_level_sync (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Asynchronous level in, settled level out.
  input wire logic async_in,
  output logic level_out
);
  logic stage1;
  logic stage2;
  logic stage3;

  // The first stage feeds only the second, so metastability cannot leak out.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A one-cycle glitch past stage two is filtered because stage three disagrees.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      level_out <= 1'b0;
    end else if (stage2 == stage3) begin
      level_out <= stage3;
    end
  end
endmodule

// *** design/opc_output_power_control.sv ***
// Output and power control byte: register, read-back and output path controls.
`timescale 1ns/1ps
// Contract
// R1 - Bit 7 low powers the chip down.
// R2 - Bit 6 lets the reference output free-run.
// R3 - Bit 4 low selects free-running 32k output.
// R4 - Bit 3 picks fourth or fifth divider.
// R5 - Bit 2 gates the reference output.
// R6 - Bits 1,0 gate fourth divider channels 3,2.
// R7 - Reserved bit 5 reads zero, ignores writes.
module opc_output_power_control (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Byte access from the serial configuration engine.
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_ack,
  // Clock sources from other domains.
  input wire logic clk32k_in,
  input wire logic fourth_output_divider_in,
  input wire logic fifth_output_divider_in,
  // Output path controls.
  output logic chip_power_down,
  output logic ref_out_free_run,
  output logic ref_out_gate,
  output logic single_out_one,
  output logic fourth_divider_channel_three_gate,
  output logic fourth_divider_channel_two_gate
);
  import opc_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic opc_hit(input logic [7:0] addr);
    opc_hit = (addr == OPC_ADDR_OUTPUT_AND_POWER_CONTROL);
  endfunction

  logic [7:0] output_and_power_control;
  logic [OPC_SYNC_INPUTS-1:0] src_async;
  logic [OPC_SYNC_INPUTS-1:0] src_sync;
  logic next_single_out_one;
  logic awake;

  // ----------------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------------
  // Reserved bit is masked on write so it can never reach any output path.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      output_and_power_control <= OPC_RESET_VALUE;
    end else if (cfg_wr && opc_hit(cfg_addr)) begin
      output_and_power_control <= cfg_wdata & OPC_WRITE_MASK; // R7
    end
  end

  // Reads answer one cycle later; unmapped addresses return zero.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= 8'h00;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_wr | cfg_rd;
      if (cfg_rd && opc_hit(cfg_addr)) begin
        cfg_rdata <= output_and_power_control & OPC_WRITE_MASK; // R7
      end else if (cfg_rd) begin
        cfg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock source synchronisers
  // ----------------------------------------------------------------------
  assign src_async[OPC_SRC_32K] = clk32k_in;
  assign src_async[OPC_SRC_FOURTH_DIVIDER] = fourth_output_divider_in;
  assign src_async[OPC_SRC_FIFTH_DIVIDER] = fifth_output_divider_in;

  generate
    for (genvar i = 0; i < OPC_SYNC_INPUTS; i++) begin : g_sync
      opc_level_sync u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .async_in(src_async[i]),
        .level_out(src_sync[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output paths
  // ----------------------------------------------------------------------
  assign awake = output_and_power_control[OPC_BIT_CHIP_SLEEP_CONTROL];

  // The 32k default keeps running in power-down; it is the low-power clock.
  always_comb begin
    if (!output_and_power_control[OPC_BIT_SINGLE_OUT_ONE_DEFAULT]) begin
      next_single_out_one = src_sync[OPC_SRC_32K]; // R3
    end else if (output_and_power_control[OPC_BIT_SINGLE_OUT_ONE_SOURCE_SELECT]) begin
      next_single_out_one = src_sync[OPC_SRC_FOURTH_DIVIDER] & awake; // R4
    end else begin
      next_single_out_one = src_sync[OPC_SRC_FIFTH_DIVIDER] & awake; // R4
    end
  end

  // Every gate drops while the chip sleeps so no divider path toggles.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chip_power_down <= 1'b0;
      ref_out_free_run <= 1'b0;
      ref_out_gate <= 1'b0;
      single_out_one <= 1'b0;
      fourth_divider_channel_three_gate <= 1'b0;
      fourth_divider_channel_two_gate <= 1'b0;
    end else begin
      chip_power_down <= !awake; // R1
      ref_out_free_run <= output_and_power_control[OPC_BIT_REF_FREE_RUN] & awake; // R2
      ref_out_gate <= output_and_power_control[OPC_BIT_REF_OUT_GATE] & awake; // R5
      single_out_one <= next_single_out_one;
      fourth_divider_channel_three_gate <=
        output_and_power_control[OPC_BIT_CHANNEL_THREE_GATE] & awake; // R6
      fourth_divider_channel_two_gate <=
        output_and_power_control[OPC_BIT_CHANNEL_TWO_GATE] & awake; // R6
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_write(logic bitval, int pos);
    cfg_wr && opc_hit(cfg_addr) && (cfg_wdata[pos] == bitval);
  endsequence

  property p_sleep;
    @(posedge clk_sys) disable iff (!nrst)
      s_write(1'b0, OPC_BIT_CHIP_SLEEP_CONTROL) |=> ##1 chip_power_down;
  endproperty
  a_sleep: assert property (p_sleep) else $error("power-down not entered"); // R1

  property p_free_run;
    @(posedge clk_sys) disable iff (!nrst)
      cfg_wr && opc_hit(cfg_addr) && (cfg_wdata[7:6] == 2'b11) |=> ##1 ref_out_free_run;
  endproperty
  a_free_run: assert property (p_free_run) else $error("reference not free-running"); // R2

  property p_default_32k;
    @(posedge clk_sys) disable iff (!nrst)
      !output_and_power_control[OPC_BIT_SINGLE_OUT_ONE_DEFAULT]
        |=> single_out_one == $past(src_sync[OPC_SRC_32K]);
  endproperty
  a_default_32k: assert property (p_default_32k) else $error("32k not routed"); // R3

  property p_fourth_output_divider_route;
    @(posedge clk_sys) disable iff (!nrst)
      (awake && output_and_power_control[OPC_BIT_SINGLE_OUT_ONE_DEFAULT] &&
       output_and_power_control[OPC_BIT_SINGLE_OUT_ONE_SOURCE_SELECT])
        |=> single_out_one == $past(src_sync[OPC_SRC_FOURTH_DIVIDER]);
  endproperty
  a_fourth_output_divider_route: assert property (p_fourth_output_divider_route) else $error("divider four not routed"); // R4

  property p_fifth_output_divider_route;
    @(posedge clk_sys) disable iff (!nrst)
      (awake && output_and_power_control[OPC_BIT_SINGLE_OUT_ONE_DEFAULT] &&
       !output_and_power_control[OPC_BIT_SINGLE_OUT_ONE_SOURCE_SELECT])
        |=> single_out_one == $past(src_sync[OPC_SRC_FIFTH_DIVIDER]);
  endproperty
  a_fifth_output_divider_route: assert property (p_fifth_output_divider_route) else $error("divider five not routed"); // R4

  property p_ref_gate;
    @(posedge clk_sys) disable iff (!nrst)
      s_write(1'b0, OPC_BIT_REF_OUT_GATE) |=> ##1 !ref_out_gate;
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("reference not gated off"); // R5

  property p_fourth_output_divider_gates;
    @(posedge clk_sys) disable iff (!nrst)
      s_write(1'b1, OPC_BIT_CHIP_SLEEP_CONTROL) |=> ##1
        {fourth_divider_channel_three_gate, fourth_divider_channel_two_gate}
          == $past(cfg_wdata[1:0], 2);
  endproperty
  a_fourth_output_divider_gates: assert property (p_fourth_output_divider_gates) else $error("channel gates wrong"); // R6

  sequence s_wr_then_rd;
    cfg_wr && opc_hit(cfg_addr) ##1 cfg_rd && !cfg_wr && opc_hit(cfg_addr);
  endsequence

  property p_readback;
    @(posedge clk_sys) disable iff (!nrst)
      s_wr_then_rd |=> cfg_rdata == ($past(cfg_wdata, 2) & OPC_WRITE_MASK);
  endproperty
  a_readback: assert property (p_readback) else $error("read-back mismatch"); // R7

  // Sleep forces every gate and the free-run enable low in the same cycle.
  property p_sleep_gates;
    @(posedge clk_sys) disable iff (!nrst)
      chip_power_down |-> !ref_out_free_run && !ref_out_gate &&
        !fourth_divider_channel_three_gate && !fourth_divider_channel_two_gate;
  endproperty
  a_sleep_gates: assert property (p_sleep_gates) else $error("gate open in sleep"); // R1

  property p_wake;
    @(posedge clk_sys) disable iff (!nrst)
      s_write(1'b1, OPC_BIT_CHIP_SLEEP_CONTROL) |=> ##1 !chip_power_down;
  endproperty
  a_wake: assert property (p_wake) else $error("chip did not wake"); // R1

  property p_free_stop;
    @(posedge clk_sys) disable iff (!nrst)
      s_write(1'b0, OPC_BIT_REF_FREE_RUN) |=> ##1 !ref_out_free_run;
  endproperty
  a_free_stop: assert property (p_free_stop) else $error("reference not stopped"); // R2

  property p_reserved_write;
    @(posedge clk_sys) disable iff (!nrst)
      cfg_wr && opc_hit(cfg_addr) |=> !output_and_power_control[OPC_BIT_RESERVED];
  endproperty
  a_reserved_write: assert property (p_reserved_write) else $error("reserved bit set"); // R7

  property p_reserved_read;
    @(posedge clk_sys) disable iff (!nrst)
      cfg_rd |=> !cfg_rdata[OPC_BIT_RESERVED];
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bit read"); // R7
endmodule

// *** tb/opc_host_model.sv ***
// Host model that issues single-byte accesses on the configuration port.
`timescale 1ns/1ps
module opc_host_model (
  // Clock.
  input wire logic clk_sys,
  // Configuration port.
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_ack
);
  // Idle port at time zero.
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end
  // One byte per strobe; a released bus shows inverted values so stale data cannot pass.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ack);
    @(negedge clk_sys);
    cfg_wr = wr;
    cfg_rd = ~wr;
    cfg_addr = addr;
    cfg_wdata = wdata;
    @(negedge clk_sys);
    rdata = cfg_rdata;
    ack = cfg_ack;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = ~addr;
    cfg_wdata = ~wdata;
  endtask
  // Write then read on the very next edge; the port takes them back to back.
  task automatic write_read(input logic [7:0] addr, input logic [7:0] wdata,
                            output logic [7:0] rdata, output logic ack);
    @(negedge clk_sys);
    cfg_wr = 1'b1;
    cfg_rd = 1'b0;
    cfg_addr = addr;
    cfg_wdata = wdata;
    @(negedge clk_sys);
    ack = cfg_ack;
    cfg_wr = 1'b0;
    cfg_rd = 1'b1;
    cfg_wdata = ~wdata;
    @(negedge clk_sys);
    rdata = cfg_rdata;
    ack = ack & cfg_ack;
    cfg_rd = 1'b0;
    cfg_addr = ~addr;
  endtask
endmodule

// *** tb/opc_output_power_control_bench.sv ***
// Self-checking bench for the output and power control byte.
`timescale 1ns/1ps
`define check_eq(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module opc_output_power_control_bench;
  import opc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr, cfg_rd, cfg_ack, single_out_one, ack;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rd;
  logic [2:0] src = 3'b000;
  logic pd, fr, gate, ch3, ch2;
  logic [7:0] v;
  logic e;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] vals [6] = '{8'hff, 8'h00, 8'hc4, 8'h83, 8'h21, 8'h8c};
  logic [11:0] so [8] = '{{8'h80, 3'b001, 1'b1}, {8'h80, 3'b110, 1'b0},
    {8'h98, 3'b010, 1'b1}, {8'h98, 3'b101, 1'b0}, {8'h90, 3'b100, 1'b1},
    {8'h90, 3'b011, 1'b0}, {8'h18, 3'b010, 1'b0}, {8'h00, 3'b001, 1'b1}};
  // Clock at 40 MHz.
  always #12.5 clk_sys = ~clk_sys;
  opc_output_power_control opc_output_power_control_i (.clk_sys(clk_sys), .nrst(nrst),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .clk32k_in(src[0]),
    .fourth_output_divider_in(src[1]), .fifth_output_divider_in(src[2]),
    .chip_power_down(pd), .ref_out_free_run(fr), .ref_out_gate(gate),
    .single_out_one(single_out_one), .fourth_divider_channel_three_gate(ch3),
    .fourth_divider_channel_two_gate(ch2));
  opc_host_model opc_host_model_i (.clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
  task automatic end_of_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    opc_host_model_i.access(1'b1, a, d, rd, ack);
    `check_eq(ack, 1'b1)
  endtask
  task automatic rd_byte(input logic [7:0] a, input logic [7:0] exp);
    opc_host_model_i.access(1'b0, a, 8'h00, rd, ack);
    `check_eq(ack, 1'b1)
    `check_eq(rd, exp)
  endtask
  // Power-down gating of every enable is the chosen reading of bit 7.
  task automatic chk_outs(input logic [7:0] x);
    repeat (2) @(negedge clk_sys);
    `check_eq(pd, ~x[7])
    `check_eq(fr, x[6] & x[7])
    `check_eq(gate, x[2] & x[7])
    `check_eq(ch3, x[1] & x[7])
    `check_eq(ch2, x[0] & x[7])
  endtask
  // Hang guard, far above the roughly 140 cycles the tests need.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end
  // Main sequence.
  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    chk_outs(8'h8c);
    rd_byte(OPC_ADDR_OUTPUT_AND_POWER_CONTROL, 8'h8c);
    for (int i = 0; i < 6; i++) begin
      wr_byte(OPC_ADDR_OUTPUT_AND_POWER_CONTROL, vals[i]);
      rd_byte(OPC_ADDR_OUTPUT_AND_POWER_CONTROL, vals[i] & 8'hdf);
      chk_outs(vals[i]);
    end
    wr_byte(8'h25, 8'h00);
    rd_byte(OPC_ADDR_OUTPUT_AND_POWER_CONTROL, 8'h8c);
    rd_byte(8'h25, 8'h00);
    // Back-to-back write and read must return the new byte at once.
    opc_host_model_i.write_read(OPC_ADDR_OUTPUT_AND_POWER_CONTROL, 8'h7e, rd, ack);
    `check_eq(ack, 1'b1)
    `check_eq(rd, 8'h5e)
    chk_outs(8'h7e);
    for (int i = 0; i < 8; i++) begin
      {v, src, e} = so[i];
      wr_byte(OPC_ADDR_OUTPUT_AND_POWER_CONTROL, v);
      repeat (8) @(negedge clk_sys);
      `check_eq(single_out_one, e)
    end
    // A second reset in mid-run must restore the power-up byte.
    nrst = 1'b0;
    @(negedge clk_sys);
    nrst = 1'b1;
    rd_byte(OPC_ADDR_OUTPUT_AND_POWER_CONTROL, 8'h8c);
    chk_outs(8'h8c);
    end_of_test();
  end
endmodule
